//--- hdl/luhi_pkg.sv
package luhi_pkg;

	// ****************************************
	// Register file addressing
	// ****************************************
	localparam int          REG_W      = 5;      // Register index width
	localparam logic [4:0]  REG_FLAGS  = 5'h10;  // Index of the status_flags_register

	// ****************************************
	// Slot cycle counter
	// ****************************************
	localparam int          CNT_W      = 8;      // Saturating slot cycle counter width
	localparam logic [7:0]  CNT_RST    = 8'h00;  // Counter reset value
	localparam logic [7:0]  CNT_MAX    = 8'hFF;  // Counter saturation value
	localparam logic [7:0]  SPLIT_MIN  = 8'h02;  // Least length of a split slot

	// ****************************************
	// Interlock sequencer states, Gray along the path except LUHI_SPLIT_LATE to LUHI_IDLE
	// ****************************************
	typedef enum logic [1:0] {
		LUHI_IDLE       = 2'h0,  // Normal slot
		LUHI_SPLIT_MA   = 2'h1,  // Split slot, memory access half
		LUHI_SPLIT_LATE = 2'h3,  // Split slot, operate/decode/fetch half
		LUHI_EXTEND     = 2'h2   // Store held for writeback operation
	} luhi_state_t;

endpackage

//--- hdl/luhi_hazard_cmp.sv
`timescale 1ns/1ps

// ****************************************
// Load-use hazard compare, purely combinational
// ****************************************
module luhi_hazard_cmp (
	input  wire logic                       old_load,      // Older instruction is a load or transfer
	input  wire logic [luhi_pkg::REG_W-1:0] old_dst,       // Older load destination
	input  wire logic                       old_dsp_wb,    // Older DSP operation now in writeback
	input  wire logic                       src_a_v,       // Follower reads operand a
	input  wire logic [luhi_pkg::REG_W-1:0] src_a,         // Follower operand a, first pointer
	input  wire logic                       src_b_v,       // Follower reads operand b
	input  wire logic [luhi_pkg::REG_W-1:0] src_b,         // Follower operand b
	input  wire logic                       ptr_v,         // Follower uses an address pointer
	input  wire logic [luhi_pkg::REG_W-1:0] ptr,           // Follower address pointer
	input  wire logic                       dst_we,        // Follower writes a register
	input  wire logic [luhi_pkg::REG_W-1:0] dst,           // Follower destination
	input  wire logic                       rd_flags,      // Follower consumes a flag
	input  wire logic                       fol_load,      // Follower is a load
	input  wire logic                       fol_mac_pinc,  // Follower is postinc_multiply_accumulate
	input  wire logic                       st_dsp,        // Store of a DSP result in memory stage
	output logic                            split_need,    // Split the current slot
	output logic                            extend_need    // Hold the store's memory access
);
	import luhi_pkg::*;

	logic hit;     // Any dependency on the load destination
	logic exempt;  // Documented no-split cases

	// Dependency and exemption decode
	always_comb begin
		hit = (src_a_v && (src_a == old_dst))
			| (src_b_v && (src_b == old_dst))
			| (ptr_v && (ptr == old_dst))
			| (dst_we && (dst == old_dst))
			| (rd_flags && (old_dst == REG_FLAGS));
		// A second load to the same register simply overwrites later
		exempt = (fol_load && dst_we && (dst == old_dst))
			| (fol_mac_pinc && (src_a == old_dst));
		split_need  = old_load && hit && !exempt;
		extend_need = old_dsp_wb && st_dsp;
	end

endmodule

//--- hdl/luhi_slot_timer.sv
`timescale 1ns/1ps

// ****************************************
// Slot length counter
// ****************************************
module luhi_slot_timer (
	input  wire logic                       clk_sys,    // Core clock
	input  wire logic                       rstn,       // Synchronous reset, active low
	input  wire logic                       slot_end,   // Slot closes this cycle
	output logic [luhi_pkg::CNT_W-1:0]      cycles_r    // Cycles spent in the open slot
);
	import luhi_pkg::*;

	// Counts up, saturates, restarts at zero when a slot closes
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			cycles_r <= CNT_RST;
		end else if (slot_end) begin
			cycles_r <= CNT_RST;
		end else if (cycles_r != CNT_MAX) begin
			cycles_r <= cycles_r + 8'h01;
		end
	end

endmodule

//--- hdl/luhi_interlock.sv
`timescale 1ns/1ps

// Summary of operation
// - Load data written only in final writeback
// - Follower reading load destination splits slot
// - Follower writing load destination also splits
// - Flag consumer after flags load splits
// - Load after load, same destination: no split
// - Postinc MAC first pointer equal: no split
// - Split slot: memory cycles plus fetch cycles
// - Consumer one instruction later: no stall
// - Pointer from load waits for transfer end
// - DSP operations execute in writeback stage
// - DSP transfer destination as pointer stalls
// - DSP result store waits for writeback op
// - Core result store causes no stall
// - Memory access first, then operate/decode/fetch
module luhi_interlock (
	input  wire logic                       clk_sys,         // Core clock, 200 MHz
	input  wire logic                       rstn,            // Synchronous reset, active low
	input  wire logic                       id_valid,        // Decoded instruction present
	input  wire logic                       id_is_load,      // Load or transfer_instruction from memory
	input  wire logic                       id_is_mem,       // Has a memory_access_stage bus cycle
	input  wire logic                       id_is_dsp_op,    // Signal-processing operation
	input  wire logic                       id_st_dsp,       // Stores a signal-processing result
	input  wire logic                       id_mac_pinc,     // postinc_multiply_accumulate
	input  wire logic                       id_rd_flags,     // Consumes a status flag, as add_with_carry
	input  wire logic                       id_src_a_v,      // Operand a valid
	input  wire logic [luhi_pkg::REG_W-1:0] id_src_a,        // Operand a, first pointer for MAC
	input  wire logic                       id_src_b_v,      // Operand b valid
	input  wire logic [luhi_pkg::REG_W-1:0] id_src_b,        // Operand b
	input  wire logic                       id_ptr_v,        // Address pointer valid
	input  wire logic [luhi_pkg::REG_W-1:0] id_ptr,          // Address pointer register
	input  wire logic                       id_dst_we,       // Writes destination
	input  wire logic [luhi_pkg::REG_W-1:0] id_dst,          // Destination register
	input  wire logic                       mem_ack,         // Data transfer of memory stage done
	input  wire logic                       if_ack,          // Instruction fetch done
	input  wire logic                       dsp_done,        // Writeback operation done
	output logic                            adv,             // Pipeline advances one slot
	output logic                            hold_ex,         // operate_stage held
	output logic                            hold_id,         // decode_stage held
	output logic                            hold_if,         // Fetch held
	output logic                            ma_req,          // Memory stage may run its bus cycle
	output logic                            if_req,          // Fetch may run
	output logic                            wb_we,           // Register write in final stage
	output logic [luhi_pkg::REG_W-1:0]      wb_dst,          // Register written
	output logic                            dsp_exec,        // DSP operation runs now
	output logic                            split_active,    // A split slot is open
	output logic [luhi_pkg::CNT_W-1:0]      slot_cycles      // Cycles in current slot
);
	import luhi_pkg::*;

	// ****************************************
	// Pipeline side-band registers
	// ****************************************
	luhi_state_t            state_r;        // Sequencer state
	luhi_state_t            state_nxt;      // Next sequencer state
	logic                   ex_v_r;         // Follower in operate stage
	logic                   ex_load_r;      // Follower is a load
	logic                   ex_mem_r;       // Follower has a bus cycle
	logic                   ex_dsp_r;       // Follower is a DSP operation
	logic                   ex_st_dsp_r;    // Follower stores a DSP result
	logic                   ex_mac_r;       // Follower is postinc MAC
	logic                   ex_flags_r;     // Follower consumes a flag
	logic                   ex_a_v_r;       // Operand a valid
	logic [REG_W-1:0]       ex_a_r;         // Operand a
	logic                   ex_b_v_r;       // Operand b valid
	logic [REG_W-1:0]       ex_b_r;         // Operand b
	logic                   ex_p_v_r;       // Pointer valid
	logic [REG_W-1:0]       ex_p_r;         // Pointer
	logic                   ex_we_r;        // Destination written
	logic [REG_W-1:0]       ex_d_r;         // Destination
	logic                   ma_v_r;         // Older in memory stage
	logic                   ma_load_r;      // Older is a load
	logic                   ma_mem_r;       // Older has a bus cycle
	logic                   ma_dsp_r;       // Older is a DSP operation
	logic                   ma_st_dsp_r;    // Older stores a DSP result
	logic                   ma_we_r;        // Older writes a register
	logic [REG_W-1:0]       ma_d_r;         // Older destination
	logic                   wb_v_r;         // Instruction in final stage
	logic                   wb_load_r;      // It is a load
	logic                   writeback_final_stage_r;       // It is a DSP operation
	logic                   wb_we_r;        // It writes a register
	logic [REG_W-1:0]       wb_d_r;         // Its destination
	logic                   ma_done_r;      // Memory half of slot finished
	logic                   if_done_r;      // Fetch half of slot finished
	logic                   split_need;     // From hazard compare
	logic                   extend_need;    // From hazard compare
	logic                   slot_done;      // Normal slot complete
	logic                   stall;          // Any interlock stall
	logic                   dsp_ok_r;       // Writeback operation ended in this slot
	logic                   ext_hold;       // Store still waiting on the operation

	// ****************************************
	// Hazard compare and slot timer
	// ****************************************
	// Only the adjacent pair is compared; older results already reached writeback
	luhi_hazard_cmp u_cmp (
		.old_load     (ma_v_r && ma_load_r),
		.old_dst      (ma_d_r),
		.old_dsp_wb   (wb_v_r && writeback_final_stage_r),
		.src_a_v      (ex_v_r && ex_a_v_r),
		.src_a        (ex_a_r),
		.src_b_v      (ex_v_r && ex_b_v_r),
		.src_b        (ex_b_r),
		.ptr_v        (ex_v_r && ex_p_v_r),
		.ptr          (ex_p_r),
		.dst_we       (ex_v_r && ex_we_r),
		.dst          (ex_d_r),
		.rd_flags     (ex_v_r && ex_flags_r),
		.fol_load     (ex_load_r),
		.fol_mac_pinc (ex_mac_r),
		.st_dsp       (ma_v_r && ma_st_dsp_r),
		.split_need   (split_need),
		.extend_need  (extend_need)
	);

	luhi_slot_timer u_tmr (
		.clk_sys  (clk_sys),
		.rstn     (rstn),
		.slot_end (adv),
		.cycles_r (slot_cycles)
	);

	// ****************************************
	// Slot completion and sequencer
	// ****************************************
	// A normal slot closes when its fetch and any bus access are both done
	assign slot_done = (ma_done_r || mem_ack || !(ma_v_r && ma_mem_r)) && (if_done_r || if_ack);
	// Once the operation has ended the store may go; without this the slot would loop
	assign ext_hold  = extend_need && !dsp_ok_r;

	// Next state; a core result store never reaches the extend path
	always_comb begin
		state_nxt = state_r;
		adv       = 1'b0;
		case (state_r)
			LUHI_IDLE: begin
				if (split_need) begin
					state_nxt = LUHI_SPLIT_MA;
				end else if (ext_hold) begin
					state_nxt = LUHI_EXTEND;
				end else begin
					adv = slot_done;
				end
			end
			LUHI_SPLIT_MA: begin
				// Load transfer first; the late half waits for it
				if (ma_done_r || mem_ack || !ma_mem_r) begin
					state_nxt = LUHI_SPLIT_LATE;
				end
			end
			LUHI_SPLIT_LATE: begin
				// Fetch cycles are added after the memory cycles
				if (if_ack) begin
					state_nxt = LUHI_IDLE;
					adv       = 1'b1;
				end
			end
			LUHI_EXTEND: begin
				if (dsp_done) begin
					state_nxt = LUHI_IDLE;
				end
			end
			default: begin
				state_nxt = LUHI_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			state_r <= LUHI_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Per-slot completion flags, cleared as the slot closes
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			ma_done_r <= 1'b0;
			if_done_r <= 1'b0;
			dsp_ok_r  <= 1'b0;
		end else if (adv) begin
			ma_done_r <= 1'b0;
			if_done_r <= 1'b0;
			dsp_ok_r  <= 1'b0;
		end else if (state_r == LUHI_IDLE) begin
			ma_done_r <= ma_done_r || (mem_ack && ma_req);
			if_done_r <= if_done_r || (if_ack && if_req);
		end else if (state_r == LUHI_EXTEND) begin
			dsp_ok_r  <= dsp_ok_r || dsp_done;
		end
	end

	// ****************************************
	// Stage hand-off on advance
	// ****************************************
	// Operate stage takes the decoded instruction
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			ex_v_r      <= 1'b0;
			ex_load_r   <= 1'b0;
			ex_mem_r    <= 1'b0;
			ex_dsp_r    <= 1'b0;
			ex_st_dsp_r <= 1'b0;
			ex_mac_r    <= 1'b0;
			ex_flags_r  <= 1'b0;
			ex_a_v_r    <= 1'b0;
			ex_a_r      <= 5'h00;
			ex_b_v_r    <= 1'b0;
			ex_b_r      <= 5'h00;
			ex_p_v_r    <= 1'b0;
			ex_p_r      <= 5'h00;
			ex_we_r     <= 1'b0;
			ex_d_r      <= 5'h00;
		end else if (adv) begin
			ex_v_r      <= id_valid;
			ex_load_r   <= id_is_load;
			ex_mem_r    <= id_is_mem;
			ex_dsp_r    <= id_is_dsp_op;
			ex_st_dsp_r <= id_st_dsp;
			ex_mac_r    <= id_mac_pinc;
			ex_flags_r  <= id_rd_flags;
			ex_a_v_r    <= id_src_a_v;
			ex_a_r      <= id_src_a;
			ex_b_v_r    <= id_src_b_v;
			ex_b_r      <= id_src_b;
			ex_p_v_r    <= id_ptr_v;
			ex_p_r      <= id_ptr;
			ex_we_r     <= id_dst_we;
			ex_d_r      <= id_dst;
		end
	end

	// Memory stage takes the operate-stage instruction
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			ma_v_r      <= 1'b0;
			ma_load_r   <= 1'b0;
			ma_mem_r    <= 1'b0;
			ma_dsp_r    <= 1'b0;
			ma_st_dsp_r <= 1'b0;
			ma_we_r     <= 1'b0;
			ma_d_r      <= 5'h00;
		end else if (adv) begin
			ma_v_r      <= ex_v_r;
			ma_load_r   <= ex_load_r;
			ma_mem_r    <= ex_mem_r;
			ma_dsp_r    <= ex_dsp_r;
			ma_st_dsp_r <= ex_st_dsp_r;
			ma_we_r     <= ex_we_r;
			ma_d_r      <= ex_d_r;
		end
	end

	// Final stage takes the memory-stage instruction
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			wb_v_r    <= 1'b0;
			wb_load_r <= 1'b0;
			writeback_final_stage_r  <= 1'b0;
			wb_we_r   <= 1'b0;
			wb_d_r    <= 5'h00;
		end else if (adv) begin
			wb_v_r    <= ma_v_r;
			wb_load_r <= ma_load_r;
			writeback_final_stage_r  <= ma_dsp_r;
			wb_we_r   <= ma_we_r;
			wb_d_r    <= ma_d_r;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign stall        = (state_r != LUHI_IDLE) || split_need || ext_hold;
	assign hold_ex      = stall && (state_r != LUHI_SPLIT_LATE);
	assign hold_id      = !adv;
	assign hold_if      = stall && (state_r != LUHI_SPLIT_LATE);
	// Extended store keeps its bus cycle back until the operation ends
	assign ma_req       = ma_v_r && ma_mem_r && !ma_done_r && (state_r != LUHI_EXTEND)
	                      && (state_r != LUHI_SPLIT_LATE) && !ext_hold;
	// Fetch only in the late half of a split, so cycles add up; never fetched twice
	assign if_req       = (state_r == LUHI_SPLIT_LATE)
	                      || ((state_r == LUHI_IDLE) && !split_need && !if_done_r);
	// Load data lands only in the final stage
	assign wb_we        = wb_v_r && wb_we_r && wb_load_r;
	assign wb_dst       = wb_d_r;
	// Signal-processing work only in the final stage, off the data bus path
	assign dsp_exec     = wb_v_r && writeback_final_stage_r;
	assign split_active = (state_r == LUHI_SPLIT_MA) || (state_r == LUHI_SPLIT_LATE);

	// ****************************************
	// Checks
	// ****************************************
	a_load_wb_only: assert property (@(posedge clk_sys) disable iff (!rstn)
		$rose(wb_we) |-> $past(adv) && $past(ma_v_r && ma_load_r))
		else $error("load write outside final stage");
	a_split_entry: assert property (@(posedge clk_sys) disable iff (!rstn)
		(state_r == LUHI_IDLE) && split_need |=> (state_r == LUHI_SPLIT_MA) && $stable(ex_d_r))
		else $error("dependent follower did not split");
	a_split_on_load: assert property (@(posedge clk_sys) disable iff (!rstn)
		$rose(split_active) |-> $past(ma_v_r && ma_load_r))
		else $error("split without adjacent load");
	a_exempt_load: assert property (@(posedge clk_sys) disable iff (!rstn)
		(state_r == LUHI_IDLE) && ex_v_r && ex_load_r && ex_we_r && ma_load_r && (ex_d_r == ma_d_r)
		&& !ex_a_v_r && !ex_b_v_r && !ex_p_v_r && !ex_flags_r |-> !split_need)
		else $error("load after same-destination load split");
	a_exempt_mac: assert property (@(posedge clk_sys) disable iff (!rstn)
		ex_v_r && ex_mac_r && (ex_a_r == ma_d_r) && !ex_b_v_r && !ex_p_v_r && !ex_we_r && !ex_flags_r
		|-> !split_need)
		else $error("postinc MAC on loaded pointer split");
	a_split_halves: assert property (@(posedge clk_sys) disable iff (!rstn)
		(state_r == LUHI_SPLIT_MA) |-> hold_ex && hold_if && !if_req)
		else $error("late stages ran in memory half");
	a_split_length: assert property (@(posedge clk_sys) disable iff (!rstn)
		(state_r == LUHI_SPLIT_LATE) && adv |-> (slot_cycles >= SPLIT_MIN - 8'h01) && if_ack)
		else $error("split slot too short");
	a_ptr_wait: assert property (@(posedge clk_sys) disable iff (!rstn)
		(state_r == LUHI_SPLIT_MA) && ma_mem_r && !ma_done_r && !mem_ack |=> (state_r == LUHI_SPLIT_MA))
		else $error("pointer access ran before load transfer");
	a_store_extend: assert property (@(posedge clk_sys) disable iff (!rstn)
		(state_r == LUHI_EXTEND) && !dsp_done |-> !ma_req ##1 (state_r == LUHI_EXTEND) || dsp_done)
		else $error("DSP store ran before writeback operation");
	a_younger_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
		stall && (state_r != LUHI_SPLIT_LATE) |-> hold_id && hold_if && !adv)
		else $error("younger stages moved during stall");
	a_dsp_in_wb: assert property (@(posedge clk_sys) disable iff (!rstn)
		dsp_exec |-> wb_v_r && !(wb_we && !wb_load_r))
		else $error("DSP operation outside final stage");

endmodule

//--- test/luhi_bus_model.sv
`timescale 1ns/1ps

// ****************************************
// Memory bus, fetch bus and DSP unit seen from the interlock
// ****************************************
module luhi_bus_model #(
	parameter int MW = 2,  // Memory-stage bus cycles
	parameter int IW = 1,  // Fetch bus cycles
	parameter int DW = 3   // Writeback operation cycles
) (
	input  wire logic clk_sys,   // Core clock
	input  wire logic rstn,      // Synchronous reset, active low
	input  wire logic ma_req,    // Memory stage bus request
	input  wire logic if_req,    // Fetch request
	input  wire logic dsp_exec,  // DSP operation running
	output logic      mem_ack,   // Memory transfer done
	output logic      if_ack,    // Fetch done
	output logic      dsp_done   // DSP operation done
);
	int cm;  // Memory wait count
	int ci;  // Fetch wait count
	int cd;  // DSP wait count

	// Quiet until the first falling edge
	initial begin
		mem_ack = 1'b0;
		if_ack = 1'b0;
		dsp_done = 1'b0;
	end

	// Acks are given only while requested, one cycle per finished wait (steady high with a one-cycle wait, as IW = 1), so a dropped request is never answered
	always @(negedge clk_sys) begin
		mem_ack <= rstn && ma_req && cm == MW - 1;
		if_ack <= rstn && if_req && ci == IW - 1;
		dsp_done <= rstn && dsp_exec && cd == DW - 1;
		cm <= (!rstn || !ma_req || cm == MW - 1) ? 0 : cm + 1;
		ci <= (!rstn || !if_req || ci == IW - 1) ? 0 : ci + 1;
		cd <= (!rstn || !dsp_exec || cd == DW - 1) ? 0 : cd + 1;
	end
endmodule

//--- test/tb_top.sv
`timescale 1ns/1ps

// ****************************************
// Interlock bench
// ****************************************
module tb_top;
	import luhi_pkg::*;
	logic             clk_sys = 1'b0;  // Core clock
	logic             rstn    = 1'b0;  // Reset, active low
	logic             id_valid = 1'b0; // Instruction present
	logic [8:0]       k  = 9'h000;     // Kind bits of the decoded instruction
	logic [REG_W-1:0] ra = 5'h00;      // Operand index
	logic [REG_W-1:0] rp = 5'h00;      // Pointer index
	logic [REG_W-1:0] rd = 5'h00;      // Destination index
	logic             mem_ack, if_ack, dsp_done, adv, hold_ex, hold_id, hold_if;
	logic             ma_req, if_req, wb_we, dsp_exec, split_active;
	logic [REG_W-1:0] wb_dst;          // Final-stage destination
	logic [REG_W-1:0] first_wb;        // First register written back
	logic             wb_seen;         // A write-back was seen
	int               n_mismatch = 0;
	int               n_tests = 0;
	int               cyc = 0;         // Cycle count for the hang guard
	int               n_split;         // Cycles with a split slot open
	int               n_ext;           // Cycles of a held DSP store

	// ****************************************
	// Clock, design and far side
	// ****************************************
	initial begin
		forever #2.5 clk_sys = ~clk_sys;
	end

	luhi_interlock dut (.clk_sys(clk_sys), .rstn(rstn), .id_valid(id_valid), .id_is_load(k[0]),
		.id_is_mem(k[1]), .id_is_dsp_op(k[2]), .id_st_dsp(k[3]), .id_mac_pinc(k[4]),
		.id_rd_flags(k[5]), .id_src_a_v(k[6]), .id_src_a(ra), .id_src_b_v(k[6]), .id_src_b(ra),
		.id_ptr_v(k[7]), .id_ptr(rp), .id_dst_we(k[8]), .id_dst(rd), .mem_ack(mem_ack),
		.if_ack(if_ack), .dsp_done(dsp_done), .adv(adv), .hold_ex(hold_ex), .hold_id(hold_id),
		.hold_if(hold_if), .ma_req(ma_req), .if_req(if_req), .wb_we(wb_we), .wb_dst(wb_dst),
		.dsp_exec(dsp_exec), .split_active(split_active), .slot_cycles());

	luhi_bus_model bus (.clk_sys(clk_sys), .rstn(rstn), .ma_req(ma_req), .if_req(if_req),
		.dsp_exec(dsp_exec), .mem_ack(mem_ack), .if_ack(if_ack), .dsp_done(dsp_done));

	// Observe stalls and write-backs; the hang guard comes last
	always @(posedge clk_sys) begin
		cyc++;
		if (split_active === 1'b1) n_split++;
		if (dsp_exec === 1'b1 && adv === 1'b0 && split_active === 1'b0) n_ext++;
		if (wb_we === 1'b1 && !wb_seen) begin
			first_wb = wb_dst;
			wb_seen = 1'b1;
		end
		if (cyc == 8000) begin
			n_mismatch++;
			end_of_test();
		end
	end

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Present one instruction and hold it until the slot advances
	task automatic issue(input logic [8:0] kk, input logic [4:0] a, input logic [4:0] p, input logic [4:0] d);
		@(negedge clk_sys);
		id_valid = 1'b1;
		k = kk;
		ra = a;
		rp = p;
		rd = d;
		#1;
		while (adv !== 1'b1) begin
			@(negedge clk_sys);
			#1;
		end
		@(posedge clk_sys);
	endtask

	// Older instruction, follower, optional third, then four valid instructions with no kind bits; judge stall and write-back
	task automatic pair(input string nm, input logic [8:0] ka, input logic [4:0] da, input logic [8:0] kb,
		input logic [4:0] ab, input logic [4:0] pb, input logic [4:0] db, input logic [8:0] kc,
		input logic es, input logic ee);
		@(negedge clk_sys);
		n_split = 0;
		n_ext = 0;
		wb_seen = 1'b0;
		issue(ka, 5'h00, 5'h00, da);
		issue(kb, ab, pb, db);
		issue(kc, da, 5'h00, 5'h00);
		repeat (4) issue(9'h000, 5'h00, 5'h00, 5'h00);
		chk(8'(n_split != 0), 8'(es));
		chk(8'(n_ext != 0), 8'(ee));
		if (es) chk(8'(n_split >= 2), 8'h01);
		if (ee) chk(8'(n_ext >= 3), 8'h01);
		chk(8'(wb_seen), 8'(ka[0]));
		if (ka[0]) chk(8'(first_wb), 8'(da));
		$display("done %s tests=%0d", nm, n_tests);
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_read; pair("read", 9'h103, 5'h03, 9'h040, 5'h03, 5'h00, 5'h00, 9'h000, 1, 0); endtask
	task automatic t_write; pair("write", 9'h103, 5'h03, 9'h100, 5'h05, 5'h00, 5'h03, 9'h000, 1, 0); endtask
	task automatic t_flag; pair("flag", 9'h103, REG_FLAGS, 9'h020, 5'h01, 5'h00, 5'h00, 9'h000, 1, 0); endtask
	task automatic t_ldld; pair("ldld", 9'h103, 5'h03, 9'h103, 5'h01, 5'h00, 5'h03, 9'h000, 0, 0); endtask
	task automatic t_mac; pair("mac", 9'h103, 5'h03, 9'h052, 5'h03, 5'h00, 5'h00, 9'h000, 0, 0); endtask
	task automatic t_later; pair("later", 9'h103, 5'h03, 9'h000, 5'h01, 5'h00, 5'h00, 9'h040, 0, 0); endtask
	task automatic t_ptr; pair("ptr", 9'h103, 5'h07, 9'h082, 5'h01, 5'h07, 5'h00, 9'h000, 1, 0); endtask
	task automatic t_dsp; pair("dsp", 9'h104, 5'h06, 9'h04A, 5'h06, 5'h00, 5'h00, 9'h000, 0, 1); endtask
	task automatic t_core; pair("core", 9'h140, 5'h06, 9'h042, 5'h06, 5'h00, 5'h00, 9'h000, 0, 0); endtask

	task automatic end_of_test;
		$display("tests=%0d mismatches=%0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		repeat (2) @(posedge clk_sys);
		@(negedge clk_sys);
		rstn = 1'b1;
		t_read();
		t_write();
		t_flag();
		t_ldld();
		t_mac();
		t_later();
		t_ptr();
		t_dsp();
		t_core();
		end_of_test();
	end
endmodule
